// [dsb_debug_segment.sv]
`timescale 1ns/100ps
`include "dsb_defines.svh"

// Functional notes
// - Debug-mode accesses inside the debug window skip address translation.
// - Window splits into probe segment below and register segment above.
// - Debug window physical address has bits 35 to 32 zero.
// - Probe gets all debug fetches, data only when normal-memory flag clear.
// - Register segment reachable only when normal-memory flag is clear.
// - Control at 0, status at 0x0C, comparators at 0x300 to 0x314.
// - Bus address/data match gives debug exception or trace trigger.
// - Core watchpoints raise debug exception when enabled over TAP.
// - Control bit 29 reads one, big-endian.
// - Control bits 17 and 16 read zero, no hardware breakpoints.
// - Control bit 4 reads one, interrupts allowed in debug mode.
// - Control bits 3 and 1 read one, bit 2 reads zero.
// - Control bit 0 mirrors probe enable of TAP control register.
// - Status bit 30 reads one, overlay support present.
// - Status bits 27 to 24 read one, single break channel.
// - Status bits 14 to 1 read zero.
// - Status bit 0 sets on bus break or bus trigger.
// - Status bit 0 clears on hard reset, probe reset, or written zero.
// - Break exception also raises the core debug-interrupt indication.

module dsb_debug_segment (
    input wire logic clock,
    input wire logic rst,
    input wire logic debug_mode,
    input wire logic loadstore_normal_memory,
    input wire logic probe_enable,
    input wire logic probe_processor_reset,
    input wire logic watchpoint_tap_instruction,
    input wire logic watch_hit,
    input wire dsb_pkg::dsb_req_t core_req,
    input wire dsb_pkg::dsb_obs_t bus_obs,
    output dsb_pkg::dsb_route_t route_r,
    output logic reg_ack_r,
    output logic [31:0] reg_rdata_r,
    output logic break_exception_r,
    output logic trace_trigger_r,
    output logic debug_interrupt_flag_r,
    output logic watch_exception_r,
    output logic break_status_flag_r
);

    // ----------------------------------------
    // Register selection
    // ----------------------------------------
    typedef enum logic [3:0] {
        SEL_NONE,
        SEL_CONTROL,
        SEL_STATUS,
        SEL_ALO,
        SEL_DVAL,
        SEL_DMSK,
        SEL_CTRL,
        SEL_AHI,
        SEL_AHM
    } dsb_sel_t;

    // Offset decode, shared by the read and the write path
    function automatic dsb_sel_t dsb_decode(input logic [`DSB_OFS_HI:0] ofs);
        dsb_sel_t s;
        s = SEL_NONE;
        case (ofs)
            `DSB_OFS_DEBUG_CONTROL: s = SEL_CONTROL;
            `DSB_OFS_BREAK_STATUS: s = SEL_STATUS;
            `DSB_OFS_ADDR_LOW: s = SEL_ALO;
            `DSB_OFS_DATA_VALUE: s = SEL_DVAL;
            `DSB_OFS_DATA_MASK: s = SEL_DMSK;
            `DSB_OFS_CTRL_ADDR_MASK: s = SEL_CTRL;
            `DSB_OFS_ADDR_HIGH: s = SEL_AHI;
            `DSB_OFS_ADDR_HIGH_MASK: s = SEL_AHM;
            default: s = SEL_NONE;
        endcase
        return s;
    endfunction

    // Write strobe for one register; keeps the compare in one place
    function automatic logic dsb_write_hit(input logic wr, input dsb_sel_t s,
        input dsb_sel_t want);
        return wr && (s == want);
    endfunction

    // ----------------------------------------
    // Internal signals
    // ----------------------------------------
    dsb_pkg::dsb_route_t route;
    dsb_sel_t sel;
    logic reg_access;
    logic reg_wr;
    logic wr_addr_low;
    logic wr_data_value;
    logic wr_data_mask;
    logic wr_ctrl;
    logic wr_addr_high;
    logic wr_addr_high_mask;
    logic wr_status;
    logic [31:0] addr_low_r;
    logic [31:0] data_value_r;
    logic [31:0] data_mask_r;
    logic [31:0] ctrl_r;
    logic [31:0] addr_high_r;
    logic [31:0] addr_high_mask_r;
    logic hit_break;
    logic hit_trigger;
    logic status_set;
    logic status_clr;
    logic break_status_nxt;
    logic [31:0] control_value;
    logic [31:0] status_value;
    logic [31:0] rdata_nxt;

    // ----------------------------------------
    // Window decode
    // ----------------------------------------
    dsb_window_decode u_decode (
        .debug_mode(debug_mode),
        .loadstore_normal_memory(loadstore_normal_memory),
        .probe_enable(probe_enable),
        .req(core_req),
        .route(route)
    );

    // Route is held one cycle so every core-facing output is a flop
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            route_r <= '0;
        end else begin
            route_r <= route;
        end
    end

    // Register access strobes
    assign reg_access = core_req.valid && route.to_regs;
    assign reg_wr = reg_access && core_req.write;
    assign sel = dsb_decode(core_req.vaddr[`DSB_OFS_HI:0]);

    // One write strobe per register keeps each register block small
    assign wr_addr_low = dsb_write_hit(reg_wr, sel, SEL_ALO);
    assign wr_data_value = dsb_write_hit(reg_wr, sel, SEL_DVAL);
    assign wr_data_mask = dsb_write_hit(reg_wr, sel, SEL_DMSK);
    assign wr_ctrl = dsb_write_hit(reg_wr, sel, SEL_CTRL);
    assign wr_addr_high = dsb_write_hit(reg_wr, sel, SEL_AHI);
    assign wr_addr_high_mask = dsb_write_hit(reg_wr, sel, SEL_AHM);
    assign wr_status = dsb_write_hit(reg_wr, sel, SEL_STATUS);

    // ----------------------------------------
    // Comparator registers
    // ----------------------------------------
    // Reset clears them all so no break fires before software sets up
    // read-only and unmapped writes reach no register
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            addr_low_r <= `DSB_REG_RESET;
        end else if (wr_addr_low) begin
            addr_low_r <= core_req.wdata;
        end
    end

    // Break data value
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            data_value_r <= `DSB_REG_RESET;
        end else if (wr_data_value) begin
            data_value_r <= core_req.wdata;
        end
    end

    // Data mask, also the upper address mask in overlay mode
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            data_mask_r <= `DSB_REG_RESET;
        end else if (wr_data_mask) begin
            data_mask_r <= core_req.wdata;
        end
    end

    // Break control and low address mask
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            ctrl_r <= `DSB_REG_RESET;
        end else if (wr_ctrl) begin
            ctrl_r <= core_req.wdata;
        end
    end

    // High address bits of the break address
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            addr_high_r <= `DSB_REG_RESET;
        end else if (wr_addr_high) begin
            addr_high_r <= core_req.wdata;
        end
    end

    // High address mask
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            addr_high_mask_r <= `DSB_REG_RESET;
        end else if (wr_addr_high_mask) begin
            addr_high_mask_r <= core_req.wdata;
        end
    end

    // ----------------------------------------
    // Bus break channel
    // ----------------------------------------
    dsb_break_match u_match (
        .addr_low(addr_low_r),
        .data_value(data_value_r),
        .data_mask(data_mask_r),
        .ctrl(ctrl_r),
        .addr_high(addr_high_r),
        .addr_high_mask(addr_high_mask_r),
        .obs(bus_obs),
        .hit_break(hit_break),
        .hit_trigger(hit_trigger)
    );

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            break_exception_r <= 1'b0;
            trace_trigger_r <= 1'b0;
        end else begin
            break_exception_r <= hit_break;
            trace_trigger_r <= hit_trigger;
        end
    end

    // debug-interrupt indication with the break exception
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            debug_interrupt_flag_r <= 1'b0;
        end else begin
            debug_interrupt_flag_r <= hit_break;
        end
    end

    // watchpoint exception gated by the TAP enable
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            watch_exception_r <= 1'b0;
        end else begin
            watch_exception_r <= watch_hit && watchpoint_tap_instruction;
        end
    end

    // ----------------------------------------
    // Break status flag
    // ----------------------------------------
    // set on break or trigger
    assign status_set = hit_break || hit_trigger;
    // probe reset or a written zero clears; ones are ignored
    assign status_clr = probe_processor_reset
        || (wr_status && !core_req.wdata[`DSB_STS_FLAG_BIT]);

    // A match in the clearing cycle must survive, so set wins
    always_comb begin
        break_status_nxt = break_status_flag_r;
        if (status_clr) begin
            break_status_nxt = 1'b0;
        end
        if (status_set) begin
            break_status_nxt = 1'b1;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            break_status_flag_r <= 1'b0;
        end else begin
            break_status_flag_r <= break_status_nxt;
        end
    end

    // ----------------------------------------
    // Read values
    // ----------------------------------------
    // Fixed capability bits plus the probe enable mirror in bit 0; all others zero
    always_comb begin
        control_value = 32'h0000_0000;
        control_value[`DSB_DBG_ENDIAN_BIT] = 1'b1;
        // bits 17 and 16 stay zero from the default above
        control_value[`DSB_DBG_INT_ALLOW_BIT] = 1'b1;
        // nmi enable and soft reset enable fixed
        control_value[`DSB_DBG_NMI_EN_BIT] = 1'b1;
        control_value[`DSB_DBG_SRST_EN_BIT] = 1'b1;
        control_value[`DSB_DBG_PROBE_EN_BIT] = probe_enable;
    end

    // Status word: fixed capability fields around the live flag
    always_comb begin
        status_value = 32'h0000_0000;
        status_value[`DSB_STS_OVERLAY_BIT] = 1'b1;
        status_value[`DSB_STS_COUNT_HI:`DSB_STS_COUNT_LO] = `DSB_STS_COUNT_VAL;
        // bits 14 to 1 stay zero
        status_value[`DSB_STS_FLAG_BIT] = break_status_flag_r;
    end

    // Read mux; writes answer with zero data
    always_comb begin
        rdata_nxt = 32'h0000_0000;
        if (reg_access && !core_req.write) begin
            case (sel)
                SEL_CONTROL: rdata_nxt = control_value;
                SEL_STATUS: rdata_nxt = status_value;
                SEL_ALO: rdata_nxt = addr_low_r;
                SEL_DVAL: rdata_nxt = data_value_r;
                SEL_DMSK: rdata_nxt = data_mask_r;
                SEL_CTRL: rdata_nxt = ctrl_r;
                SEL_AHI: rdata_nxt = addr_high_r;
                SEL_AHM: rdata_nxt = addr_high_mask_r;
                default: rdata_nxt = 32'h0000_0000;
            endcase
        end
    end

    // ----------------------------------------
    // Register answer
    // ----------------------------------------
    // One-cycle answer; data of the status flag shows the value before this cycle
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            reg_ack_r <= 1'b0;
            reg_rdata_r <= `DSB_REG_RESET;
        end else begin
            reg_ack_r <= reg_access;
            reg_rdata_r <= rdata_nxt;
        end
    end

endmodule

// [dsb_defines.svh]
`ifndef DSB_DEFINES_SVH
`define DSB_DEFINES_SVH

// ----------------------------------------
// Debug window decode
// ----------------------------------------
`define DSB_WIN_TAG 11'h07F9
`define DSB_WIN_TAG_HI 31
`define DSB_WIN_TAG_LO 21
`define DSB_SEG_BIT 20
`define DSB_OFS_HI 19
`define DSB_PHYS_HI_ZERO 4'h0

// ----------------------------------------
// Register offsets in the register segment
// ----------------------------------------
`define DSB_OFS_DEBUG_CONTROL 20'h0_0000
`define DSB_OFS_BREAK_STATUS 20'h0_000C
`define DSB_OFS_ADDR_LOW 20'h0_0300
`define DSB_OFS_DATA_VALUE 20'h0_0304
`define DSB_OFS_DATA_MASK 20'h0_0308
`define DSB_OFS_CTRL_ADDR_MASK 20'h0_030C
`define DSB_OFS_ADDR_HIGH 20'h0_0310
`define DSB_OFS_ADDR_HIGH_MASK 20'h0_0314

// ----------------------------------------
// Fixed register fields
// ----------------------------------------
`define DSB_DBG_ENDIAN_BIT 29
`define DSB_DBG_INT_ALLOW_BIT 4
`define DSB_DBG_NMI_EN_BIT 3
`define DSB_DBG_SRST_EN_BIT 1
`define DSB_DBG_PROBE_EN_BIT 0
`define DSB_STS_OVERLAY_BIT 30
`define DSB_STS_COUNT_HI 27
`define DSB_STS_COUNT_LO 24
`define DSB_STS_COUNT_VAL 4'h1
`define DSB_STS_FLAG_BIT 0
`define DSB_REG_RESET 32'h0000_0000

// ----------------------------------------
// Break control fields
// ----------------------------------------
`define DSB_CTL_BREAK_EN 0
`define DSB_CTL_TRIG_EN 1
`define DSB_CTL_DATA_EN 2
`define DSB_CTL_OVERLAY_EN 3
`define DSB_CTL_LAM_HI 31
`define DSB_CTL_LAM_LO 8
`define DSB_HI_ADDR_TOP 3
`define DSB_OVL_MASK_HI 31
`define DSB_OVL_MASK_LO 24

`endif

// [dsb_pkg.sv]
package dsb_pkg;

    // ----------------------------------------
    // Core access request
    // ----------------------------------------
    typedef struct packed {
        logic valid;
        logic fetch;
        logic write;
        logic [31:0] vaddr;
        logic [31:0] wdata;
    } dsb_req_t;

    // ----------------------------------------
    // Routing decision for one access
    // ----------------------------------------
    typedef struct packed {
        logic valid;
        logic bypass;
        logic to_probe;
        logic to_regs;
        logic to_memory;
        logic probe_off_err;
        logic [35:0] paddr;
    } dsb_route_t;

    // ----------------------------------------
    // Observed core bus cycle
    // ----------------------------------------
    typedef struct packed {
        logic valid;
        logic [35:0] paddr;
        logic [31:0] data;
    } dsb_obs_t;

endpackage

// [dsb_window_decode.sv]
`timescale 1ns/100ps
`include "dsb_defines.svh"

module dsb_window_decode (
    input wire logic debug_mode,
    input wire logic loadstore_normal_memory,
    input wire logic probe_enable,
    input wire dsb_pkg::dsb_req_t req,
    output dsb_pkg::dsb_route_t route
);

    logic in_win;
    logic reg_seg;
    logic probe_svc;

    // Window hit only counts in debug mode
    assign in_win = debug_mode
        && (req.vaddr[`DSB_WIN_TAG_HI:`DSB_WIN_TAG_LO] == `DSB_WIN_TAG);
    assign reg_seg = req.vaddr[`DSB_SEG_BIT];
    // fetches always, data only with flag clear
    assign probe_svc = in_win && !reg_seg && (req.fetch || !loadstore_normal_memory);

    // Routing; the fallback is ordinary memory, with translation bypassed for window hits
    always_comb begin
        route.valid = req.valid;
        route.bypass = in_win;
        // no probe traffic while probe disabled
        route.to_probe = probe_svc && probe_enable;
        route.probe_off_err = probe_svc && !probe_enable;
        // register segment only with flag clear
        route.to_regs = in_win && reg_seg && !loadstore_normal_memory;
        route.to_memory = !(probe_svc || route.to_regs);
        // upper physical bits forced to zero
        route.paddr = {`DSB_PHYS_HI_ZERO, req.vaddr};
    end

endmodule

// [dsb_break_match.sv]
`timescale 1ns/100ps
`include "dsb_defines.svh"

module dsb_break_match (
    input wire logic [31:0] addr_low,
    input wire logic [31:0] data_value,
    input wire logic [31:0] data_mask,
    input wire logic [31:0] ctrl,
    input wire logic [31:0] addr_high,
    input wire logic [31:0] addr_high_mask,
    input wire dsb_pkg::dsb_obs_t obs,
    output logic hit_break,
    output logic hit_trigger
);

    logic overlay;
    logic [35:0] amask;
    logic [31:0] dmask;
    logic match;

    assign overlay = ctrl[`DSB_CTL_OVERLAY_EN];
    // Overlay borrows the data mask top byte as the address mask
    assign amask = {addr_high_mask[`DSB_HI_ADDR_TOP:0],
                    overlay ? data_mask[`DSB_OVL_MASK_HI:`DSB_OVL_MASK_LO] : 8'h00,
                    ctrl[`DSB_CTL_LAM_HI:`DSB_CTL_LAM_LO]};
    // Data compare is meaningless while the mask serves the address
    assign dmask = (ctrl[`DSB_CTL_DATA_EN] && !overlay) ? data_mask : 32'hFFFF_FFFF;

    assign match = obs.valid
        && ((({addr_high[`DSB_HI_ADDR_TOP:0], addr_low} ^ obs.paddr) & ~amask)
            == 36'h0_0000_0000)
        && (((data_value ^ obs.data) & ~dmask) == 32'h0000_0000);
    assign hit_break = match && ctrl[`DSB_CTL_BREAK_EN];
    assign hit_trigger = match && ctrl[`DSB_CTL_TRIG_EN];

endmodule

// [dsb_probe_model.sv]
`timescale 1ns/100ps
// ----------------------------------------
// Probe stand-in on the far side of the probe segment
// ----------------------------------------
module dsb_probe_model (
    input wire logic clock,
    input wire logic rst,
    input wire dsb_pkg::dsb_route_t route,
    output logic [7:0] probe_cnt
);
    // serve forwarded accesses
    // Counts only; a flagged access with the probe off never reaches here
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            probe_cnt <= 8'h00;
        end else if (route.valid && route.to_probe) begin
            probe_cnt <= probe_cnt + 8'h01;
        end
    end
endmodule

// [dsb_assertions.sv]
`timescale 1ns/100ps
module dsb_chk (
    input wire logic clock,
    input wire logic rst,
    input wire logic debug_mode,
    input wire logic loadstore_normal_memory,
    input wire logic probe_enable,
    input wire logic probe_processor_reset,
    input wire logic watchpoint_tap_instruction,
    input wire logic watch_hit,
    input wire dsb_pkg::dsb_req_t core_req,
    input wire dsb_pkg::dsb_obs_t bus_obs,
    input wire dsb_pkg::dsb_route_t route_r,
    input wire logic reg_ack_r,
    input wire logic [31:0] reg_rdata_r,
    input wire logic break_exception_r,
    input wire logic trace_trigger_r,
    input wire logic debug_interrupt_flag_r,
    input wire logic watch_exception_r,
    input wire logic break_status_flag_r
);
    // ----------------------------------------
    // Window decode seen from the core side
    // ----------------------------------------
    logic win;
    logic up;
    logic rd;
    // Helpers recompute the decode independently of the design
    assign win = core_req.valid && debug_mode && core_req.vaddr[31:21] == 11'h7F9;
    assign up = win && core_req.vaddr[20] && !loadstore_normal_memory;
    assign rd = up && !core_req.write;
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    property p_bypass; win |=> route_r.bypass && route_r.paddr == {4'h0, $past(core_req.vaddr)}; endproperty
    a_bypass: assert property (p_bypass) else $error("window map wrong");
    property p_ack; up |=> reg_ack_r && route_r.to_regs; endproperty
    a_ack: assert property (p_ack) else $error("register access not answered");
    property p_probe; win && !core_req.vaddr[20] && core_req.fetch && probe_enable |=> route_r.to_probe; endproperty
    a_probe: assert property (p_probe) else $error("fetch not forwarded");
    property p_normal_mem; win && core_req.vaddr[20] && loadstore_normal_memory |=> !reg_ack_r && route_r.to_memory; endproperty
    a_normal_mem: assert property (p_normal_mem) else $error("register segment reachable");
    property p_ctl; rd && core_req.vaddr[19:0] == 20'h0_0000 |=> reg_rdata_r == {31'h1000_000D, $past(probe_enable)}; endproperty
    a_ctl: assert property (p_ctl) else $error("control value wrong");
    property p_sts; rd && core_req.vaddr[19:0] == 20'h0_000C |=> reg_rdata_r[31:1] == 31'h2080_0000; endproperty
    a_sts: assert property (p_sts) else $error("status fields wrong");
    property p_debug_interrupt_flag; break_exception_r |-> debug_interrupt_flag_r && break_status_flag_r; endproperty
    a_debug_interrupt_flag: assert property (p_debug_interrupt_flag) else $error("break without flags");
    property p_rise; $rose(break_status_flag_r) |-> break_exception_r || trace_trigger_r; endproperty
    a_rise: assert property (p_rise) else $error("flag set without event");
    property p_clr; probe_processor_reset && !bus_obs.valid |=> !break_status_flag_r; endproperty
    a_clr: assert property (p_clr) else $error("flag survived probe reset");
    property p_watch; watch_hit && watchpoint_tap_instruction |=> watch_exception_r; endproperty
    a_watch: assert property (p_watch) else $error("watch exception missing");
    c_reg: cover property (up ##1 reg_ack_r);
    c_brk: cover property (break_exception_r);
    c_trg: cover property (trace_trigger_r);
endmodule
bind dsb_debug_segment dsb_chk u_chk (.clock, .rst, .debug_mode, .loadstore_normal_memory,
    .probe_enable, .probe_processor_reset, .watchpoint_tap_instruction, .watch_hit,
    .core_req, .bus_obs, .route_r, .reg_ack_r, .reg_rdata_r, .break_exception_r,
    .trace_trigger_r, .debug_interrupt_flag_r, .watch_exception_r, .break_status_flag_r);

// [tb_top.sv]
`timescale 1ns/100ps
module tb_top;
    logic clock, rst, dm, nm, pe, ppr, wti, wh;
    logic ack, bx, tt, di, wx, flag;
    logic [31:0] rd;
    logic [7:0] pc;
    dsb_pkg::dsb_req_t req;
    dsb_pkg::dsb_obs_t obs;
    dsb_pkg::dsb_route_t rt;
    int n_fail;
    int compares;
    // Each row: {debug, normal mem, probe on, fetch}, address, {bypass, probe, regs, mem, err}
    logic [40:0] tbl [7] = '{{4'b1010, 32'hFF20_0010, 5'b11000},
        {4'b1111, 32'hFF2F_FFFC, 5'b11000}, {4'b1110, 32'hFF20_0000, 5'b10010},
        {4'b1000, 32'hFF20_0004, 5'b10001}, {4'b0011, 32'hFF20_0000, 5'b00010},
        {4'b1010, 32'hFF40_0000, 5'b00010}, {4'b1110, 32'hFF30_000C, 5'b10010}};
`define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin n_fail++; \
    $display("Error %s expected %h seen %h", n, e, s); end end
    dsb_debug_segment DUT (.clock(clock), .rst(rst), .debug_mode(dm),
        .loadstore_normal_memory(nm), .probe_enable(pe), .probe_processor_reset(ppr),
        .watchpoint_tap_instruction(wti), .watch_hit(wh), .core_req(req), .bus_obs(obs),
        .route_r(rt), .reg_ack_r(ack), .reg_rdata_r(rd), .break_exception_r(bx),
        .trace_trigger_r(tt), .debug_interrupt_flag_r(di), .watch_exception_r(wx),
        .break_status_flag_r(flag));
    dsb_probe_model u_probe (.clock(clock), .rst(rst), .route(rt), .probe_cnt(pc));
    // ----------------------------------------
    // Drivers: everything changes 1 ns after the rising edge
    // ----------------------------------------
    // One core access; on return the registered answer is settled
    task automatic acc(input logic f, input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge clock);
        #1 req = '{1'b1, f, w, a, d};
        @(posedge clock);
        #1 req = '0;
    endtask
    task automatic wr(input logic [31:0] o, input logic [31:0] d);
        acc(1'b0, 1'b1, 32'hFF30_0000 + o, d);
    endtask
    // Register read with a check of data and answer
    task automatic rdc(input logic [31:0] o, input logic [31:0] e);
        acc(1'b0, 1'b0, 32'hFF30_0000 + o, 32'h0000_0000);
        `CHK("rdata", e, rd)
        `CHK("ack", 1'b1, ack)
    endtask
    // One observed bus cycle at the given physical address
    task automatic bus(input logic [35:0] p);
        @(posedge clock);
        #1 obs = '{1'b1, p, 32'h0000_0000};
        @(posedge clock);
        #1 obs = '0;
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_route;
        for (int i = 0; i < 7; i++) begin
            {dm, nm, pe} = tbl[i][40:38];
            acc(tbl[i][37], 1'b0, tbl[i][36:5], 32'h0000_0000);
            `CHK("route", tbl[i][4:0], {rt.bypass, rt.to_probe, rt.to_regs, rt.to_memory, rt.probe_off_err})
            `CHK("ack", 1'b0, ack)
            if (tbl[i][4]) `CHK("paddr", {4'h0, tbl[i][36:5]}, rt.paddr)
        end
        `CHK("probe count", 8'h02, pc)
    endtask
    task automatic t_regs;
        nm = 1'b0;
        rdc(32'h0, 32'h2000_001B);
        pe = 0;
        wr(32'h0, 32'hFFFF_FFFF);
        rdc(32'h0, 32'h2000_001A);
        rdc(32'hC, 32'h4100_0000);
        for (int i = 0; i < 6; i++) wr(32'h300 + 4 * i, 32'hA5A5_0000 + i);
        for (int i = 0; i < 6; i++) rdc(32'h300 + 4 * i, 32'hA5A5_0000 + i);
        wr(32'h4, 32'h1234_5678);
        rdc(32'h4, 32'h0000_0000);
        rdc(32'h318, 32'h0000_0000);
    endtask
    task automatic t_break;
        for (int i = 0; i < 6; i++) wr(32'h300 + 4 * i, (i == 0) ? 32'h1000 : (i == 3));
        bus(36'h0_0000_2000);
        `CHK("no break", 2'b00, {bx, flag})
        bus(36'h0_0000_1000);
        `CHK("break", 4'b1110, {bx, di, flag, tt})
        wr(32'hC, 32'h0000_0001);
        rdc(32'hC, 32'h4100_0001);
        // Handler clears the flag before leaving debug mode
        wr(32'hC, 32'h0000_0000);
        rdc(32'hC, 32'h4100_0000);
        wr(32'h30C, 32'h0000_0002);
        bus(36'h0_0000_1000);
        `CHK("trigger", 3'b101, {tt, bx, flag})
        @(posedge clock);
        #1 ppr = 1;
        @(posedge clock);
        #1 ppr = 0;
        `CHK("flag", 1'b0, flag)
    endtask
    task automatic t_watch;
        for (int i = 1; i >= 0; i--) begin
            wti = i[0];
            @(posedge clock);
            #1 wh = 1;
            @(posedge clock);
            #1 wh = 0;
            `CHK("watch", i[0], wx)
        end
    endtask
    task automatic close_out;
        if (n_fail == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // Clock at 250 MHz
    initial begin
        clock = 0;
        forever #2 clock = ~clock;
    end
    // Reset for 3 cycles, then the scenarios in turn
    initial begin
        {rst, dm, nm, pe, ppr, wti, wh} = 7'b1000000;
        req = '0;
        obs = '0;
        repeat (3) @(posedge clock);
        #1 rst = 0;
        t_route();
        t_regs();
        t_break();
        t_watch();
        close_out();
    end
    // Watchdog well beyond the roughly 90 cycles the run needs
    initial begin
        #20000;
        n_fail++;
        close_out();
    end
endmodule
